// ==== hw/sfpc_defines.svh ====
`ifndef SFPC_DEFINES_SVH
`define SFPC_DEFINES_SVH

// register offsets
`define SFPC_ADDR_FIFO_CFG 8'h08
`define SFPC_ADDR_SLOT_ONE_TWO 8'h09
`define SFPC_ADDR_SLOT_THREE_FOUR 8'h0a
`define SFPC_ADDR_SYS_CTRL 8'h0d

// field positions
`define SFPC_SYS_BUF_EN 2
`define SFPC_SYS_POWER_SAVE 1
`define SFPC_SYS_SOFT_RST 0

// reset values
`define SFPC_RST_A_FULL_THR 4'hf
`define SFPC_RST_SLOT_REG 8'h00
`define SFPC_RST_SYS_CTRL 3'h0

// sizes
`define SFPC_SAMPLE_MAX 6'h20
`define SFPC_ELEM_BITS 24
`define SFPC_SLOTS 4
`define SFPC_STAGE_DEPTH 16
`define SFPC_STORE_DEPTH 128

`endif

// ==== hw/sfpc_pkg.sv ====
package sfpc_pkg;

    typedef enum logic [3:0] {
        SFPC_SLOT_EMPTY = 4'h0,
        SFPC_SLOT_OPTICAL_CHANNEL_ONE = 4'h1,
        SFPC_SLOT_OPTICAL_CHANNEL_TWO = 4'h2,
        SFPC_SLOT_PILOT_CHANNEL_ONE = 4'h5,
        SFPC_SLOT_PILOT_CHANNEL_TWO = 4'h6,
        SFPC_SLOT_ECG = 4'h9
    } sfpc_slot_t;

    typedef enum logic [1:0] {
        SFPC_ST_IDLE = 2'b01,
        SFPC_ST_PACK = 2'b10
    } sfpc_state_t;

    function automatic logic sfpc_slot_used(input logic [3:0] code);
        logic used;
        used = 1'b0;
        unique case (code)
            SFPC_SLOT_OPTICAL_CHANNEL_ONE, SFPC_SLOT_OPTICAL_CHANNEL_TWO,
            SFPC_SLOT_PILOT_CHANNEL_ONE, SFPC_SLOT_PILOT_CHANNEL_TWO,
            SFPC_SLOT_ECG: used = 1'b1;
            default: used = 1'b0;
        endcase
        return used;
    endfunction : sfpc_slot_used

endpackage : sfpc_pkg

// ==== hw/sfpc_fifo.sv ====
`timescale 1ns/1ps
module sfpc_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clear,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    // depth must be a power of two so the pointers wrap by themselves
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = DEPTH[AW:0];

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0] cnt_r, cnt_nxt;
    logic ready_r, ready_nxt, oval_r, oval_nxt;
    logic [WIDTH-1:0] odat_r, odat_nxt;
    logic push, load;

    assign push = in_valid && ready_r;
    assign load = (cnt_r != '0) && (!oval_r || out_ready);
    assign in_ready = ready_r;
    assign out_valid = oval_r;
    assign out_data = odat_r;

    always_comb begin
        wp_nxt = push ? wp_r + 1'b1 : wp_r;
        rp_nxt = load ? rp_r + 1'b1 : rp_r;
        cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
        oval_nxt = load ? 1'b1 : (out_ready ? 1'b0 : oval_r);
        odat_nxt = load ? mem[rp_r] : odat_r;
        if (clear) begin
            wp_nxt = '0;
            rp_nxt = '0;
            cnt_nxt = '0;
            oval_nxt = 1'b0;
        end
        ready_nxt = (cnt_nxt != FULL_CNT);
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_r] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
            ready_r <= 1'b0;
            oval_r <= 1'b0;
            odat_r <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
            ready_r <= ready_nxt;
            oval_r <= oval_nxt;
            odat_r <= odat_nxt;
        end
    end
endmodule : sfpc_fifo

// ==== hw/sfpc_top.sv ====
// Summary of operation
// [R1] almost_full sets when the free sample space equals the 4-bit threshold (0 at 32, 15 at 17).
// [R2] the buffer holds at most 32 samples of up to four 3-byte elements each.
// [R3] slot codes decode as empty, optical one/two, pilot one/two, ecg; others are reserved.
// [R4] register 0x09 holds slot one type in bits 3:0 and slot two type in 7:4, reset zero.
// [R5] register 0x0a holds slot three type in bits 3:0 and slot four type in 7:4, reset zero.
// [R6] with buffer enable low no sample is pushed and pointers and stored data are held; the code still pushes a sample whose packing began while enabled.
// [R7] writing buffer enable as one flushes stored data and restarts from pointer zero.
// [R8] in power save every register keeps its value and reads and writes still work.
// [R9] entering power save forces the interrupt flag low and keeps it low meanwhile.
// [R10] in power save the internal oscillator is stopped.
// [R11] a conversion in progress when power save is set finishes before shutdown.
// [R12] in power save no conversion result is taken, so stored results stay as they were.
// [R13] writing one to the reset bit returns every register to its reset value, then the bit clears.
// [R14] the write pointer advances by one per pushed sample and names the next slot to fill.
// [R15] a sample carries used slots in order one to four, each element read msb byte first.
// [R16] the host changes slot types only with the buffer disabled, then enables to flush.
`timescale 1ns/1ps
`include "sfpc_defines.svh"
module sfpc_top (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata_r,
    output logic reg_rvalid_r,
    // conversion results
    input wire logic conv_active,
    input wire logic conv_valid,
    input wire logic [95:0] conv_result,
    output logic conv_ready_r,
    // sample readout
    input wire logic data_rd,
    output logic [7:0] data_byte_r,
    output logic data_valid_r,
    // status
    input wire logic almost_full_clr,
    output logic almost_full_r,
    output logic [4:0] write_pointer_r,
    output logic [5:0] sample_count_r,
    output logic osc_enable_r
);
    import sfpc_pkg::*;

    localparam int EW = `SFPC_ELEM_BITS;

    // configuration state
    logic [3:0] a_full_thr_r, a_full_thr_nxt;
    logic [7:0] slot_one_two_r, slot_one_two_nxt;
    logic [7:0] slot_three_four_r, slot_three_four_nxt;
    logic buf_en_r, buf_en_nxt, power_save_r, power_save_nxt;
    logic soft_rst_r, soft_rst_nxt;
    logic [7:0] rdata_nxt;
    logic rvalid_nxt;

    // packing and buffer state
    sfpc_state_t state_r, state_nxt;
    logic [1:0] slot_idx_r, slot_idx_nxt;
    logic [95:0] conv_buf_r, conv_buf_nxt;
    logic conv_ready_nxt, osc_nxt, af_nxt;
    logic [4:0] wp_nxt;
    logic [5:0] count_nxt;
    logic [1:0] byte_idx_r, byte_idx_nxt;
    logic [2:0] rd_elem_r, rd_elem_nxt;
    logic [7:0] byte_nxt;
    logic dvalid_nxt;

    // internal nets
    logic [3:0] slot_code [4];
    logic [3:0] slot_used;
    logic [2:0] active_cnt;
    logic flush, wr_sys, accept, commit, sample_out, af_evt;
    logic stage_in_valid, stage_in_ready, stage_out_valid, store_in_ready;
    logic store_out_valid, store_out_ready;
    logic [EW-1:0] stage_in_data, stage_out_data, store_out_data;
    logic [5:0] count_after, free_after;

    assign slot_code[0] = slot_one_two_r[3:0];
    assign slot_code[1] = slot_one_two_r[7:4];
    assign slot_code[2] = slot_three_four_r[3:0];
    assign slot_code[3] = slot_three_four_r[7:4];

    // reserved codes are treated as empty so they never take buffer space
    for (genvar i = 0; i < `SFPC_SLOTS; i++) begin : g_slot
        assign slot_used[i] = sfpc_slot_used(slot_code[i]); // [R3]
    end

    assign active_cnt = {2'b00, slot_used[0]} + {2'b00, slot_used[1]}
        + {2'b00, slot_used[2]} + {2'b00, slot_used[3]};

    assign wr_sys = reg_wr && !soft_rst_r && (reg_addr == `SFPC_ADDR_SYS_CTRL);
    assign flush = soft_rst_r || (wr_sys && reg_wdata[`SFPC_SYS_BUF_EN]); // [R7] [R13]

    // register file; power save gates nothing here so access stays normal
    always_comb begin
        a_full_thr_nxt = a_full_thr_r;
        slot_one_two_nxt = slot_one_two_r;
        slot_three_four_nxt = slot_three_four_r;
        buf_en_nxt = buf_en_r;
        power_save_nxt = power_save_r;
        soft_rst_nxt = 1'b0; // [R13]
        rvalid_nxt = reg_rd;
        rdata_nxt = 8'h00;
        if (reg_wr && !soft_rst_r) begin // [R8]
            unique case (reg_addr)
                `SFPC_ADDR_FIFO_CFG: a_full_thr_nxt = reg_wdata[3:0];
                `SFPC_ADDR_SLOT_ONE_TWO: slot_one_two_nxt = reg_wdata; // [R4]
                `SFPC_ADDR_SLOT_THREE_FOUR: slot_three_four_nxt = reg_wdata; // [R5]
                `SFPC_ADDR_SYS_CTRL: begin
                    buf_en_nxt = reg_wdata[`SFPC_SYS_BUF_EN];
                    power_save_nxt = reg_wdata[`SFPC_SYS_POWER_SAVE];
                    soft_rst_nxt = reg_wdata[`SFPC_SYS_SOFT_RST];
                end
                default: ;
            endcase
        end
        if (reg_rd) begin
            unique case (reg_addr)
                `SFPC_ADDR_FIFO_CFG: rdata_nxt = {4'h0, a_full_thr_r};
                `SFPC_ADDR_SLOT_ONE_TWO: rdata_nxt = slot_one_two_r;
                `SFPC_ADDR_SLOT_THREE_FOUR: rdata_nxt = slot_three_four_r;
                `SFPC_ADDR_SYS_CTRL: rdata_nxt = {5'h00, buf_en_r, power_save_r, soft_rst_r};
                default: rdata_nxt = 8'h00;
            endcase
        end
        if (soft_rst_r) begin // [R13]
            a_full_thr_nxt = `SFPC_RST_A_FULL_THR;
            slot_one_two_nxt = `SFPC_RST_SLOT_REG;
            slot_three_four_nxt = `SFPC_RST_SLOT_REG;
            {buf_en_nxt, power_save_nxt, soft_rst_nxt} = `SFPC_RST_SYS_CTRL;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            a_full_thr_r <= `SFPC_RST_A_FULL_THR;
            slot_one_two_r <= `SFPC_RST_SLOT_REG;
            slot_three_four_r <= `SFPC_RST_SLOT_REG;
            {buf_en_r, power_save_r, soft_rst_r} <= `SFPC_RST_SYS_CTRL;
            reg_rdata_r <= 8'h00;
            reg_rvalid_r <= 1'b0;
        end else begin
            a_full_thr_r <= a_full_thr_nxt;
            slot_one_two_r <= slot_one_two_nxt;
            slot_three_four_r <= slot_three_four_nxt;
            buf_en_r <= buf_en_nxt;
            power_save_r <= power_save_nxt;
            soft_rst_r <= soft_rst_nxt;
            reg_rdata_r <= rdata_nxt;
            reg_rvalid_r <= rvalid_nxt;
        end
    end

    // a conversion is taken whole; it is stored only if enabled, used and not full
    assign accept = conv_valid && conv_ready_r;
    assign stage_in_valid = (state_r == SFPC_ST_PACK) && slot_used[slot_idx_r] && !flush;
    assign stage_in_data = conv_buf_r[slot_idx_r*EW +: EW];
    assign commit = (state_r == SFPC_ST_PACK) && (slot_idx_r == 2'd3) && !flush
        && (!slot_used[3] || stage_in_ready);

    // readout walks msb byte first and pops the element after its last byte
    assign store_out_ready = data_rd && store_out_valid && (byte_idx_r == 2'd2); // [R15]
    assign sample_out = store_out_ready && ((rd_elem_r + 3'd1) == active_cnt);
    assign count_after = sample_count_r + {5'h00, commit} - {5'h00, sample_out};
    assign free_after = `SFPC_SAMPLE_MAX - count_after;
    assign af_evt = commit && (free_after == {2'b00, a_full_thr_r}); // [R1]

    always_comb begin
        state_nxt = state_r;
        slot_idx_nxt = slot_idx_r;
        conv_buf_nxt = conv_buf_r;
        wp_nxt = write_pointer_r;
        count_nxt = count_after;
        byte_idx_nxt = byte_idx_r;
        rd_elem_nxt = rd_elem_r;
        byte_nxt = data_byte_r;
        dvalid_nxt = 1'b0;
        af_nxt = almost_full_r;
        unique case (state_r)
            SFPC_ST_IDLE: begin
                if (accept && buf_en_r && (active_cnt != 3'd0)
                    && (sample_count_r != `SFPC_SAMPLE_MAX)) begin // [R2] [R6]
                    conv_buf_nxt = conv_result;
                    slot_idx_nxt = 2'd0;
                    state_nxt = SFPC_ST_PACK;
                end
            end
            SFPC_ST_PACK: begin
                if (!slot_used[slot_idx_r] || stage_in_ready) begin // [R15]
                    slot_idx_nxt = slot_idx_r + 2'd1;
                    if (slot_idx_r == 2'd3) begin
                        state_nxt = SFPC_ST_IDLE;
                    end
                end
            end
            default: state_nxt = SFPC_ST_IDLE;
        endcase
        if (commit) begin
            wp_nxt = write_pointer_r + 5'd1; // [R14]
        end
        if (data_rd && store_out_valid) begin
            dvalid_nxt = 1'b1;
            unique case (byte_idx_r)
                2'd0: byte_nxt = store_out_data[23:16];
                2'd1: byte_nxt = store_out_data[15:8];
                default: byte_nxt = store_out_data[7:0];
            endcase
            byte_idx_nxt = (byte_idx_r == 2'd2) ? 2'd0 : byte_idx_r + 2'd1;
        end
        if (store_out_ready) begin
            rd_elem_nxt = sample_out ? 3'd0 : rd_elem_r + 3'd1;
        end
        // host clear loses to a new event
        if (almost_full_clr) begin
            af_nxt = 1'b0;
        end
        if (af_evt) begin
            af_nxt = 1'b1;
        end
        if (power_save_r) begin
            af_nxt = 1'b0; // [R9]
        end
        if (flush) begin // [R7]
            state_nxt = SFPC_ST_IDLE;
            slot_idx_nxt = 2'd0;
            wp_nxt = 5'd0;
            count_nxt = 6'd0;
            byte_idx_nxt = 2'd0;
            rd_elem_nxt = 3'd0;
            dvalid_nxt = 1'b0;
        end
        if (soft_rst_r) begin // [R13]
            conv_buf_nxt = '0;
            byte_nxt = 8'h00;
            af_nxt = 1'b0;
        end
        // stop only once no conversion is running or being packed
        osc_nxt = !(power_save_nxt && !conv_active && (state_nxt == SFPC_ST_IDLE)); // [R10] [R11]
        // no new results while the oscillator is stopped
        conv_ready_nxt = osc_nxt && !power_save_nxt && (state_nxt == SFPC_ST_IDLE); // [R12]
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= SFPC_ST_IDLE;
            slot_idx_r <= 2'd0;
            conv_buf_r <= '0;
            write_pointer_r <= 5'd0;
            sample_count_r <= 6'd0;
            byte_idx_r <= 2'd0;
            rd_elem_r <= 3'd0;
            data_byte_r <= 8'h00;
            data_valid_r <= 1'b0;
            almost_full_r <= 1'b0;
            osc_enable_r <= 1'b1;
            conv_ready_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            slot_idx_r <= slot_idx_nxt;
            conv_buf_r <= conv_buf_nxt;
            write_pointer_r <= wp_nxt;
            sample_count_r <= count_nxt;
            byte_idx_r <= byte_idx_nxt;
            rd_elem_r <= rd_elem_nxt;
            data_byte_r <= byte_nxt;
            data_valid_r <= dvalid_nxt;
            almost_full_r <= af_nxt;
            osc_enable_r <= osc_nxt;
            conv_ready_r <= conv_ready_nxt;
        end
    end

    // staging decouples packing from the store; its ready stalls the packer
    sfpc_fifo #(
        .WIDTH(EW),
        .DEPTH(`SFPC_STAGE_DEPTH)
    ) u_stage (
        .clk(clk),
        .rst_b(rst_b),
        .clear(flush),
        .in_valid(stage_in_valid),
        .in_ready(stage_in_ready),
        .in_data(stage_in_data),
        .out_valid(stage_out_valid),
        .out_ready(store_in_ready),
        .out_data(stage_out_data)
    );

    // element store, 32 samples of four elements
    sfpc_fifo #(
        .WIDTH(EW),
        .DEPTH(`SFPC_STORE_DEPTH)
    ) u_store (
        .clk(clk),
        .rst_b(rst_b),
        .clear(flush),
        .in_valid(stage_out_valid),
        .in_ready(store_in_ready),
        .in_data(stage_out_data),
        .out_valid(store_out_valid),
        .out_ready(store_out_ready),
        .out_data(store_out_data)
    );
endmodule : sfpc_top

// ==== test/sfpc_top_assertions.sv ====
`timescale 1ns/1ps
module sfpc_top_assertions (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata_r,
    input wire logic reg_rvalid_r,
    // conversion results
    input wire logic conv_active,
    input wire logic conv_valid,
    input wire logic [95:0] conv_result,
    input wire logic conv_ready_r,
    // readout and status
    input wire logic data_rd,
    input wire logic [7:0] data_byte_r,
    input wire logic data_valid_r,
    input wire logic almost_full_clr,
    input wire logic almost_full_r,
    input wire logic [4:0] write_pointer_r,
    input wire logic [5:0] sample_count_r,
    input wire logic osc_enable_r
);
    logic ps_r;
    logic ps_nxt;
    logic en_r;
    logic en_nxt;
    // mirror of the control bits, since only the ports are visible here
    always_comb begin
        ps_nxt = ps_r;
        en_nxt = en_r;
        if (reg_wr && reg_addr == 8'h0d) begin
            ps_nxt = reg_wdata[1];
            en_nxt = reg_wdata[2];
        end
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ps_r <= 1'b0;
            en_r <= 1'b0;
        end else begin
            ps_r <= ps_nxt;
            en_r <= en_nxt;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_accept;
        conv_valid && conv_ready_r;
    endsequence
    sequence s_stored;
        s_accept ##1 !conv_ready_r;
    endsequence
    // one cycle per slot, ready comes back the cycle after the last slot
    sequence s_packing;
        !conv_ready_r [*4];
    endsequence
    chk_read_answer: assert property (reg_rd |=> reg_rvalid_r)
        else $error("read strobe not answered");
    chk_read_cause: assert property (reg_rvalid_r |-> $past(reg_rd))
        else $error("read valid without a read");
    chk_rdata_idle: assert property (!reg_rvalid_r |-> reg_rdata_r == 8'h00)
        else $error("read data not idle");
    chk_pack_gap: assert property (s_stored |-> s_packing ##1 (conv_ready_r || ps_r))
        else $error("packing did not take four slot cycles");
    chk_flag_save: assert property (ps_r && $past(ps_r) |-> !almost_full_r)
        else $error("flag high in power save");
    chk_ready_save: assert property (ps_r && $past(ps_r) |-> !conv_ready_r)
        else $error("result taken in power save");
    chk_osc_cause: assert property (!osc_enable_r |-> ps_r && !$past(conv_active))
        else $error("oscillator stopped without cause");
    chk_ptr_step: assert property (write_pointer_r != $past(write_pointer_r)
        |-> write_pointer_r == $past(write_pointer_r) + 5'h01 || write_pointer_r == 5'h00)
        else $error("write pointer jumped");
    // a soft reset clears the pointer two cycles after its write
    chk_hold_off: assert property (!en_r && !$past(en_r) && !$past(reg_wr)
        && !$past(reg_wr, 2) |-> $stable(write_pointer_r))
        else $error("pointer moved while disabled");
    chk_flush_zero: assert property (reg_wr && reg_addr == 8'h0d && reg_wdata[2]
        && !reg_wdata[0] |=> ##[0:1] write_pointer_r == 5'h00 && sample_count_r == 6'h00)
        else $error("enable did not flush");
    chk_soft_reset: assert property (reg_wr && reg_addr == 8'h0d && reg_wdata[0]
        |=> ##1 write_pointer_r == 5'h00 && sample_count_r == 6'h00 && !almost_full_r)
        else $error("soft reset left state behind");
    chk_count_cap: assert property (sample_count_r <= 6'h20)
        else $error("sample count above capacity");
    chk_data_cause: assert property (data_valid_r |-> $past(data_rd))
        else $error("byte valid without a request");
endmodule : sfpc_top_assertions

bind sfpc_top sfpc_top_assertions u_chk (.clk, .rst_b, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata_r, .reg_rvalid_r, .conv_active, .conv_valid, .conv_result, .conv_ready_r,
    .data_rd, .data_byte_r, .data_valid_r, .almost_full_clr, .almost_full_r,
    .write_pointer_r, .sample_count_r, .osc_enable_r);

// ==== test/sfpc_conv_model.sv ====
`timescale 1ns/1ps
module sfpc_conv_model (
    // clock
    input wire logic clk,
    // conversion port
    output logic conv_active,
    output logic conv_valid,
    output logic [95:0] conv_result,
    input wire logic conv_ready_r
);
    initial begin
        conv_active = 1'b0;
        conv_valid = 1'b0;
        conv_result = '0;
    end
    // converts for lag cycles, then holds the offer until ready is seen high
    task automatic send(input logic [95:0] word, input int lag);
        @(posedge clk);
        conv_active <= 1'b1;
        repeat (lag) @(posedge clk);
        conv_valid <= 1'b1;
        conv_result <= word;
        do @(posedge clk); while (conv_ready_r !== 1'b1);
        conv_valid <= 1'b0;
        conv_active <= 1'b0;
        // a withdrawn offer must not keep showing the old word
        conv_result <= ~word;
    endtask : send
endmodule : sfpc_conv_model

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    typedef struct packed {logic [7:0] addr; logic [7:0] wdata; logic [7:0] rdata;} sfpc_reg_row_t;
    typedef struct packed {logic [3:0] code; logic [7:0] count;} sfpc_slot_row_t;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata_r;
    logic reg_rvalid_r;
    logic conv_active;
    logic conv_valid;
    logic [95:0] conv_result;
    logic conv_ready_r;
    logic data_rd = 1'b0;
    logic [7:0] data_byte_r;
    logic data_valid_r;
    logic almost_full_clr = 1'b0;
    logic almost_full_r;
    logic [4:0] write_pointer_r;
    logic [5:0] sample_count_r;
    logic osc_enable_r;
    int err_count = 0;
    int num_checks = 0;
    sfpc_reg_row_t regs [4] = '{'{8'h09, 8'ha5, 8'ha5}, '{8'h0a, 8'h5a, 8'h5a},
        '{8'h0b, 8'hff, 8'h00}, '{8'h08, 8'hff, 8'h0f}};
    sfpc_slot_row_t slots [8] = '{'{4'h0, 8'h00}, '{4'h1, 8'h01}, '{4'h2, 8'h01},
        '{4'h5, 8'h01}, '{4'h6, 8'h01}, '{4'h9, 8'h01}, '{4'h3, 8'h00}, '{4'hf, 8'h00}};
    logic [7:0] rb [9] = '{8'ha1, 8'ha2, 8'ha3, 8'hb1, 8'hb2, 8'hb3, 8'hd4, 8'hd5, 8'hd6};
    always #5 clk = ~clk;
    sfpc_top u_dut (.clk, .rst_b, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata_r,
        .reg_rvalid_r, .conv_active, .conv_valid, .conv_result, .conv_ready_r, .data_rd,
        .data_byte_r, .data_valid_r, .almost_full_clr, .almost_full_r, .write_pointer_r,
        .sample_count_r, .osc_enable_r);
    sfpc_conv_model u_src (.clk, .conv_active, .conv_valid, .conv_result, .conv_ready_r);
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        check("reg_rvalid", {7'h00, reg_rvalid_r}, 8'h01);
        check("reg_rdata", reg_rdata_r, exp);
    endtask : rd
    task automatic byte_rd(input logic v, input logic [7:0] exp);
        @(posedge clk);
        data_rd <= 1'b1;
        @(posedge clk);
        data_rd <= 1'b0;
        #1;
        check("data_valid", {7'h00, data_valid_r}, {7'h00, v});
        check("data_byte", data_byte_r, exp);
    endtask : byte_rd
    // the store needs a few cycles after packing, so settle before looking
    task automatic sample();
        u_src.send(96'hd4d5d6_c7c8c9_b1b2b3_a1a2a3, 2);
        repeat (8) @(posedge clk);
    endtask : sample
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : summarize
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        $display("watchdog expired");
        summarize();
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        rd(8'h08, 8'h0f);
        rd(8'h09, 8'h00);
        rd(8'h0a, 8'h00);
        rd(8'h0d, 8'h00);
        $display("test reset done");
        foreach (regs[i]) begin
            wr(regs[i].addr, regs[i].wdata);
            rd(regs[i].addr, regs[i].rdata);
        end
        $display("test registers done");
        wr(8'h0a, 8'h00);
        foreach (slots[i]) begin
            wr(8'h0d, 8'h00);
            wr(8'h09, {4'h0, slots[i].code});
            wr(8'h0d, 8'h04);
            sample();
            check("count", {2'b00, sample_count_r}, slots[i].count);
            check("pointer", {3'h0, write_pointer_r}, slots[i].count);
        end
        $display("test slot codes done");
        wr(8'h0d, 8'h00);
        wr(8'h09, 8'h21);
        wr(8'h0a, 8'h90);
        wr(8'h0d, 8'h04);
        sample();
        foreach (rb[i]) byte_rd(1'b1, rb[i]);
        byte_rd(1'b0, 8'hd6);
        check("count", {2'b00, sample_count_r}, 8'h00);
        $display("test readout done");
        wr(8'h0d, 8'h00);
        wr(8'h09, 8'h01);
        wr(8'h0a, 8'h00);
        wr(8'h0d, 8'h04);
        repeat (16) sample();
        check("almost_full", {7'h00, almost_full_r}, 8'h00);
        sample();
        check("almost_full", {7'h00, almost_full_r}, 8'h01);
        wr(8'h0d, 8'h00);
        sample();
        check("count", {2'b00, sample_count_r}, 8'h11);
        check("pointer", {3'h0, write_pointer_r}, 8'h11);
        wr(8'h0d, 8'h02);
        repeat (3) @(posedge clk);
        #1;
        check("almost_full", {7'h00, almost_full_r}, 8'h00);
        check("osc_enable", {7'h00, osc_enable_r}, 8'h00);
        check("conv_ready", {7'h00, conv_ready_r}, 8'h00);
        rd(8'h09, 8'h01);
        wr(8'h0a, 8'h12);
        rd(8'h0a, 8'h12);
        check("count", {2'b00, sample_count_r}, 8'h11);
        $display("test power save done");
        wr(8'h0d, 8'h01);
        repeat (3) @(posedge clk);
        rd(8'h0a, 8'h00);
        rd(8'h0d, 8'h00);
        check("count", {2'b00, sample_count_r}, 8'h00);
        check("osc_enable", {7'h00, osc_enable_r}, 8'h01);
        $display("test soft reset done");
        wr(8'h09, 8'h09);
        wr(8'h08, 8'h00);
        wr(8'h0d, 8'h04);
        repeat (33) sample();
        check("count", {2'b00, sample_count_r}, 8'h20);
        check("pointer", {3'h0, write_pointer_r}, 8'h00);
        check("almost_full", {7'h00, almost_full_r}, 8'h01);
        @(posedge clk);
        almost_full_clr <= 1'b1;
        @(posedge clk);
        almost_full_clr <= 1'b0;
        #1;
        check("almost_full", {7'h00, almost_full_r}, 8'h00);
        $display("test full buffer done");
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        rd(8'h08, 8'h0f);
        rd(8'h09, 8'h00);
        check("count", {2'b00, sample_count_r}, 8'h00);
        check("pointer", {3'h0, write_pointer_r}, 8'h00);
        $display("test second reset done");
        summarize();
    end
endmodule : tb_top
